// File: bb_detach_pkg.sv
package bb_detach_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_TMO_LOW = 16'h413E;
  localparam logic [15:0] IDX_TMO_HIGH = 16'h413F;
  localparam logic [15:0] IDX_CTRL = 16'h4140;
  localparam logic [15:0] IDX_DESC_BASE = 16'h4141;
  localparam int DESC_WORDS = 12;
  localparam int DESC_BYTES = 48;
  // reset values
  localparam logic [15:0] TMO_RST = 16'h07D0;
  localparam logic CTRL_EN_RST = 1'b1;
  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_BB_BIT = 8;
  localparam int CTRL_RUN_BIT = 9;
  // descriptor byte positions with named defaults, some of them zero
  localparam int DB_URL_IDX = 3;
  localparam int DB_NUM_MODES = 4;
  localparam int DB_PREF_MODE = 5;
  localparam int DB_VCONN_LO = 6;
  localparam int DB_VCONN_HI = 7;
  localparam int DB_CFG0 = 8;
  localparam int DB_BCD_LO = 40;
  localparam int DB_BCD_HI = 41;
  localparam int DB_SVID_HI = 45;
  localparam logic [7:0] URL_IDX_RST = 8'h01;
  localparam logic [7:0] NUM_MODES_RST = 8'h01;
  localparam logic [7:0] PREF_MODE_RST = 8'h00;
  localparam logic [7:0] VCONN_LO_RST = 8'h00;
  localparam logic [7:0] VCONN_HI_RST = 8'h80;
  localparam logic [7:0] CFG_UNSPEC_ERR = 8'h00;
  localparam logic [7:0] BCD_LO_RST = 8'h10;
  localparam logic [7:0] BCD_HI_RST = 8'h01;
  localparam logic [7:0] SVID_HI_RST = 8'hFF;
  // timing
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int TICK_TIME_MS = 10;
  localparam int TICK_CYCLES_DFLT = (CLK_FREQ_HZ / 1000) * TICK_TIME_MS;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_DEFAULT = 3'b000,
    ST_BB_DETACH = 3'b001,
    ST_BB_ACTIVE = 3'b010,
    ST_BB_TIMING = 3'b011,
    ST_DEF_DETACH = 3'b100
  } bb_state_e;
endpackage

// File: bb_detach_timer.sv
`timescale 1ns/10ps
module bb_detach_timer import bb_detach_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input wire logic sys_clk_in, // core clock
  input wire logic rst_in, // synchronous reset, high
  input wire logic billboard_trigger_input_in, // pin, low asks for billboard
  input wire logic string_req_in, // pulse: host fetched alternate-mode string
  input wire logic [5:0] desc_addr_in, // descriptor byte index
  output logic [7:0] desc_data_out, // descriptor byte, one cycle later
  output logic detach_out, // high for one cycle while detaching
  output logic billboard_mode_out, // high while billboard descriptors shown
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  function automatic logic is_desc(input logic [15:0] idx);
    is_desc = (idx >= IDX_DESC_BASE) && (idx < IDX_DESC_BASE + 16'(DESC_WORDS));
  endfunction

  function automatic logic [7:0] desc_default(input int i);
    case (i)
      DB_URL_IDX: desc_default = URL_IDX_RST;
      DB_NUM_MODES: desc_default = NUM_MODES_RST;
      DB_PREF_MODE: desc_default = PREF_MODE_RST;
      DB_VCONN_LO: desc_default = VCONN_LO_RST;
      DB_VCONN_HI: desc_default = VCONN_HI_RST;
      DB_BCD_LO: desc_default = BCD_LO_RST;
      DB_BCD_HI: desc_default = BCD_HI_RST;
      DB_SVID_HI: desc_default = SVID_HI_RST;
      default: desc_default = CFG_UNSPEC_ERR;
    endcase
  endfunction

  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, araddr_q;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] tmo_q, tmo_d;
  logic en_q, en_d;
  logic [7:0] desc_q [DESC_BYTES];
  logic [7:0] desc_d [DESC_BYTES];
  logic [7:0] dout_q;
  logic wr_fire;
  logic [15:0] wr_idx, rd_idx;
  logic trig_s1_q, trig_s2_q, trig_s3_q, trig_stable_q, trig_stable_d;
  bb_state_e state_q, state_d;
  logic [31:0] tick_q, tick_d;
  logic [15:0] remain_q, remain_d;
  logic tick_hit, expire, start, trig_fall;

  // axi handshake outputs
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = awaddr_q[17:2];
  assign rd_idx = s_axi_araddr[17:2];

  // write channel capture, register writes and read answer
  always_comb
  begin
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    tmo_d = tmo_q;
    en_d = en_q;
    desc_d = desc_q;
    if (s_axi_awvalid && !aw_held_q)
    begin
      awaddr_d = s_axi_awaddr;
      aw_held_d = 1'b1;
    end
    if (s_axi_wvalid && !w_held_q)
    begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_held_d = 1'b1;
    end
    if (wr_fire)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (wr_idx == IDX_TMO_LOW)
      begin
        if (wstrb_q[0]) tmo_d[7:0] = wdata_q[7:0];
      end
      else if (wr_idx == IDX_TMO_HIGH)
      begin
        if (wstrb_q[0]) tmo_d[15:8] = wdata_q[7:0];
      end
      else if (wr_idx == IDX_CTRL)
      begin
        if (wstrb_q[0]) en_d = wdata_q[CTRL_EN_BIT];
      end
      else if (is_desc(wr_idx))
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (wstrb_q[b]) desc_d[int'(wr_idx - IDX_DESC_BASE) * 4 + b] = wdata_q[b*8 +: 8];
        end
      end
      else
      begin
        bresp_d = RESP_SLVERR;
      end
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (rd_idx == IDX_TMO_LOW) rdata_d[7:0] = tmo_q[7:0];
      else if (rd_idx == IDX_TMO_HIGH) rdata_d[7:0] = tmo_q[15:8];
      else if (rd_idx == IDX_CTRL)
      begin
        rdata_d[CTRL_EN_BIT] = en_q;
        rdata_d[CTRL_BB_BIT] = billboard_mode_out;
        rdata_d[CTRL_RUN_BIT] = (state_q == ST_BB_TIMING);
      end
      else if (is_desc(rd_idx))
      begin
        for (int b = 0; b < 4; b++)
        begin
          rdata_d[b*8 +: 8] = desc_q[int'(rd_idx - IDX_DESC_BASE) * 4 + b];
        end
      end
      else rresp_d = RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  // register bank and bus state
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      tmo_q <= TMO_RST;
      en_q <= CTRL_EN_RST;
      for (int i = 0; i < DESC_BYTES; i++) desc_q[i] <= desc_default(i);
    end
    else
    begin
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      tmo_q <= tmo_d;
      en_q <= en_d;
      desc_q <= desc_d;
    end
  end

  // descriptor byte port toward the endpoint
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in) dout_q <= 8'h00;
    else dout_q <= desc_q[desc_addr_in < 6'(DESC_BYTES) ? desc_addr_in : 6'h00];
  end
  assign desc_data_out = dout_q;

  // trigger pin: three flops, level accepted when second and third agree
  assign trig_stable_d = (trig_s2_q == trig_s3_q) ? trig_s3_q : trig_stable_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      trig_s1_q <= 1'b1;
      trig_s2_q <= 1'b1;
      trig_s3_q <= 1'b1;
      trig_stable_q <= 1'b1;
    end
    else
    begin
      trig_s1_q <= billboard_trigger_input_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      trig_stable_q <= trig_stable_d;
    end
  end
  assign trig_fall = trig_stable_q && !trig_stable_d;

  assign start = string_req_in && (state_q == ST_BB_ACTIVE);
  assign tick_hit = (tick_q == TICK_CYCLES - 1);
  assign expire = (state_q == ST_BB_TIMING) && (remain_q == 16'h0000);

  // attach sequencing and detach timer
  always_comb
  begin
    state_d = state_q;
    tick_d = tick_q;
    remain_d = remain_q;
    case (state_q)
      ST_DEFAULT: if (trig_fall && en_q) state_d = ST_BB_DETACH;
      ST_BB_DETACH: state_d = ST_BB_ACTIVE;
      ST_BB_ACTIVE:
      begin
        if (start)
        begin
          state_d = ST_BB_TIMING;
          remain_d = tmo_q;
          tick_d = 32'd0;
        end
      end
      ST_BB_TIMING:
      begin
        if (expire) state_d = ST_DEF_DETACH;
        else if (tick_hit)
        begin
          tick_d = 32'd0;
          remain_d = remain_q - 16'd1;
        end
        else tick_d = tick_q + 32'd1;
      end
      ST_DEF_DETACH: state_d = ST_DEFAULT;
      default: state_d = ST_DEFAULT;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_DEFAULT;
      tick_q <= 32'd0;
      remain_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      tick_q <= tick_d;
      remain_q <= remain_d;
    end
  end

  assign detach_out = (state_q == ST_BB_DETACH) || (state_q == ST_DEF_DETACH);
  assign billboard_mode_out = (state_q == ST_BB_ACTIVE) || (state_q == ST_BB_TIMING);

  // checks
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  timer_start_a: assert property (start |=> state_q == ST_BB_TIMING && remain_q == $past(tmo_q))
    else $error("timer did not start on string request");
  expiry_detach_a: assert property (expire |=> detach_out ##1 !billboard_mode_out && state_q == ST_DEFAULT)
    else $error("expiry did not detach and reattach default");
  tick_step_a: assert property (state_q == ST_BB_TIMING && !expire && tick_hit |=> remain_q == $past(remain_q) - 16'd1)
    else $error("timeout unit step wrong");
  tick_hold_a: assert property (state_q == ST_BB_TIMING && !tick_hit |=> remain_q == $past(remain_q))
    else $error("count moved before a full unit");
  tmo_reset_a: assert property (@(posedge sys_clk_in) disable iff (1'b0) $past(rst_in) |-> tmo_q == TMO_RST)
    else $error("timeout reset value wrong");
  high_byte_a: assert property (wr_fire && wr_idx == IDX_TMO_HIGH && wstrb_q[0] |=> tmo_q[15:8] == $past(wdata_q[7:0]))
    else $error("high byte not written");
  desc_reset_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    $past(rst_in) |-> desc_q[DB_URL_IDX] == URL_IDX_RST && desc_q[DB_CFG0] == CFG_UNSPEC_ERR)
    else $error("descriptor defaults wrong");
  caps_reset_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    $past(rst_in) |-> desc_q[DB_NUM_MODES] == NUM_MODES_RST && desc_q[DB_PREF_MODE] == PREF_MODE_RST)
    else $error("mode count defaults wrong");
  vconn_reset_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    $past(rst_in) |-> desc_q[DB_VCONN_LO] == VCONN_LO_RST && desc_q[DB_VCONN_HI] == VCONN_HI_RST)
    else $error("vconn defaults wrong");
  trigger_attach_a: assert property (state_q == ST_DEFAULT && trig_fall && en_q |=> detach_out ##1 billboard_mode_out)
    else $error("trigger did not attach billboard");
  desc_read_a: assert property (desc_addr_in < 6'(DESC_BYTES) |=> desc_data_out == $past(desc_q[desc_addr_in]))
    else $error("descriptor byte order wrong");
  zero_tmo_a: assert property (start && tmo_q == 16'h0000 |=> ##1 state_q == ST_DEF_DETACH)
    else $error("zero timeout not immediate");
  stopped_a: assert property (state_q == ST_DEFAULT && !trig_fall |=> !detach_out && state_q == ST_DEFAULT)
    else $error("timer restarted on its own");
  trigger_c: cover property (state_q == ST_DEFAULT ##1 state_q == ST_BB_DETACH);
  start_c: cover property (start);
  expire_c: cover property (expire ##1 state_q == ST_DEF_DETACH);
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule // bb_detach_timer

// File: host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic sys_clk_in, // core clock
  input wire logic [7:0] desc_data_in, // descriptor byte returned
  output logic string_req_out, // alternate-mode string fetch pulse
  output logic [5:0] desc_addr_out // descriptor byte asked for
);
  // idle host: no fetch, address parked
  initial
  begin
    string_req_out = 1'b0;
    desc_addr_out = 6'h00;
  end
  // one-cycle fetch of the alternate-mode string
  task automatic fetch_string();
    @(posedge sys_clk_in);
    string_req_out <= 1'b1;
    @(posedge sys_clk_in);
    string_req_out <= 1'b0;
  endtask
  // one descriptor byte; data trails the address by a cycle
  task automatic get_byte(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    desc_addr_out <= a;
    @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    d = desc_data_in;
    desc_addr_out <= ~a; // released: keep the address moving
  endtask
endmodule // host_model

// File: tb.sv
`timescale 1ns/10ps
module tb;
  import bb_detach_pkg::*;
  localparam int TICK = 4;
  localparam int LIMIT = 5000;
  typedef struct {logic [15:0] idx; logic [31:0] data; logic [1:0] resp;} row_s;
  logic sys_clk_in, rst_in, trig, sreq, detach, bb_mode;
  logic [5:0] daddr;
  logic [7:0] ddata;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  row_s rows[10] = '{'{16'h413E, 32'h000000D0, RESP_OKAY}, '{16'h413F, 32'h00000007, RESP_OKAY},
    '{16'h4140, 32'h00000001, RESP_OKAY}, '{16'h4141, 32'h01000000, RESP_OKAY},
    '{16'h4142, 32'h80000001, RESP_OKAY}, '{16'h4143, 32'h00000000, RESP_OKAY},
    '{16'h414A, 32'h00000000, RESP_OKAY}, '{16'h414B, 32'h00000110, RESP_OKAY},
    '{16'h414C, 32'h0000FF00, RESP_OKAY}, '{16'h414D, 32'h00000000, RESP_SLVERR}};
  bb_detach_timer #(.TICK_CYCLES(TICK)) u_bb_detach_timer (.sys_clk_in, .rst_in,
    .billboard_trigger_input_in(trig), .string_req_in(sreq), .desc_addr_in(daddr), .desc_data_out(ddata),
    .detach_out(detach), .billboard_mode_out(bb_mode), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  host_model u_host_model (.sys_clk_in, .desc_data_in(ddata), .string_req_out(sreq), .desc_addr_out(daddr));
  // 125 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // cycle count and hang guard
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bus write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_awaddr <= {14'h0000, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // bus read
  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_araddr <= {14'h0000, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // wait for a detach pulse, bounded
  task automatic wait_det(input int max);
    int n;
    n = 0;
    while (detach !== 1'b1 && n < max)
    begin
      @(posedge sys_clk_in);
      n++;
    end
  endtask
  // no detach may show for k cycles
  task automatic quiet(input int k);
    repeat (k)
    begin
      @(posedge sys_clk_in);
      chk("detach idle", 32'h0, {31'h0, detach});
    end
  endtask
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b;
    int t0;
    rst_in = 1'b1;
    trig = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    foreach (rows[i])
    begin
      axi_rd(rows[i].idx, d, r);
      chk("read resp", {30'h0, rows[i].resp}, {30'h0, r});
      if (rows[i].resp === RESP_OKAY) chk("read data", rows[i].data, d);
    end
    // register and descriptor storage
    axi_wr(IDX_TMO_HIGH, 32'hFFFFFFA5, r);
    chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    axi_wr(16'h414D, 32'h0, r);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(IDX_TMO_HIGH, d, r);
    chk("timeout high", 32'h000000A5, d);
    axi_wr(16'h414A, 32'h44332211, r);
    u_host_model.get_byte(6'd37, b);
    chk("desc byte 37", 32'h22, {24'h0, b});
    u_host_model.get_byte(6'(DB_VCONN_HI), b);
    chk("vconn high", 32'h80, {24'h0, b});
    // fetch outside billboard is ignored
    u_host_model.fetch_string();
    quiet(20);
    axi_rd(IDX_CTRL, d, r);
    chk("status idle", 32'h00000001, d);
    // timed detach with a count of 50
    axi_wr(IDX_TMO_HIGH, 32'h0, r);
    axi_wr(IDX_TMO_LOW, 32'h32, r);
    trig <= 1'b0;
    wait_det(20);
    chk("trigger detach", 32'h1, {31'h0, detach});
    @(posedge sys_clk_in);
    chk("billboard on", 32'h1, {31'h0, bb_mode});
    u_host_model.fetch_string();
    t0 = cyc;
    axi_rd(IDX_CTRL, d, r);
    chk("status timing", 32'h00000301, d);
    wait_det(400);
    chk("interval", 32'h1, {31'h0, (cyc - t0 >= 49 * TICK) && (cyc - t0 <= 50 * TICK + 4)});
    @(posedge sys_clk_in);
    chk("billboard off", 32'h0, {31'h0, bb_mode});
    quiet(20);
    // zero count fires at once
    axi_wr(IDX_TMO_LOW, 32'h0, r);
    trig <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    trig <= 1'b0;
    wait_det(20);
    @(posedge sys_clk_in);
    chk("billboard again", 32'h1, {31'h0, bb_mode});
    u_host_model.fetch_string();
    t0 = cyc;
    wait_det(20);
    chk("zero count", 32'h1, {31'h0, cyc - t0 <= 4});
    // trigger ignored while billboard support is disabled
    axi_wr(IDX_CTRL, 32'h0, r);
    chk("ctrl write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    trig <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    trig <= 1'b0;
    quiet(10);
    axi_rd(IDX_CTRL, d, r);
    chk("status disabled", 32'h00000000, d);
    axi_wr(IDX_CTRL, 32'h1, r);
    // reset in mid-run restores the default count
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    axi_rd(IDX_TMO_HIGH, d, r);
    chk("timeout reset", 32'h00000007, d);
    axi_rd(IDX_TMO_LOW, d, r);
    chk("timeout low reset", 32'h000000D0, d);
    results();
  end
endmodule // tb
